// >>> bench/icd_header_props.sv
// Purpose: Port-level assertions for the IDE header decode
// Assumes: Bound to icd_header, one clock, synchronous reset
// Notes:   Covers show the main modes were reached
`timescale 1ns/100ps
`default_nettype none
module icd_header_props
    import icd_pkg::*;
(
    input wire logic         clk_i,
    input wire logic         srst_i,
    input wire icd_cfg_req_s cfg_i,
    input wire icd_io_req_s  io_i,
    input wire logic [31:0]  cfg_rdata_o,
    input wire logic         cfg_rvalid_o,
    input wire icd_hit_s     hit_o,
    input wire logic         pri_native_o,
    input wire logic         sec_native_o,
    input wire logic         primary_native_irq_o,
    input wire logic         secondary_native_irq_o,
    input wire logic [7:0]   int_line_o,
    input wire logic [7:0]   int_pin_o
);
    // One clock domain, reset masks every property
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    logic any_nat;
    // Either channel in native mode
    assign any_nat = pri_native_o | sec_native_o;
    // Interrupt ownership and interrupt field values follow the mode bits
    a_pri_irq_mode: assert property (primary_native_irq_o == pri_native_o)
        else $error("primary irq ownership wrong");
    a_sec_irq_mode: assert property (secondary_native_irq_o == sec_native_o)
        else $error("secondary irq ownership wrong");
    a_pin_value: assert property (int_pin_o == (any_nat ? 8'h01 : 8'h00))
        else $error("interrupt pin value wrong");
    a_legacy_line_zero: assert property (!any_nat |-> int_line_o == 8'h00)
        else $error("line not zero in legacy");
    // Mode select write lands on the following edge
    a_mode_capture: assert property (cfg_i.wr && cfg_i.addr == 8'h08 && cfg_i.be[1]
        |=> pri_native_o == $past(cfg_i.wdata[8]) && sec_native_o == $past(cfg_i.wdata[10]))
        else $error("mode select not captured");
    // Legacy windows decode while the channel is in compatibility mode
    a_pri_legacy_dec: assert property (io_i.valid && !pri_native_o
        && io_i.addr[31:3] == 29'h3E |-> hit_o.pri_cmd) else $error("legacy 1F0 miss");
    a_sec_legacy_dec: assert property (io_i.valid && !sec_native_o
        && io_i.addr == 32'h376 |-> hit_o.sec_ctl) else $error("legacy 376 miss");
    // Hidden base and fixed class bytes on read
    a_base_hidden: assert property (cfg_i.rd && cfg_i.addr == 8'h10 && !pri_native_o
        |=> cfg_rvalid_o && cfg_rdata_o == 32'h0) else $error("legacy base visible");
    a_class_const: assert property (cfg_i.rd && cfg_i.addr == 8'h08
        |=> cfg_rdata_o[31:12] == 20'h01018 && cfg_rdata_o[11] && cfg_rdata_o[9])
        else $error("class bytes wrong");
    c_both_native: cover property (pri_native_o && sec_native_o);
    c_line_set: cover property (int_line_o != 8'h00);
    c_native_hit: cover property (pri_native_o && hit_o.pri_cmd);
endmodule // icd_header_props
bind icd_header icd_header_props u_props (.clk_i(clk_i), .srst_i(srst_i), .cfg_i(cfg_i),
    .io_i(io_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .hit_o(hit_o),
    .pri_native_o(pri_native_o), .sec_native_o(sec_native_o),
    .primary_native_irq_o(primary_native_irq_o),
    .secondary_native_irq_o(secondary_native_irq_o), .int_line_o(int_line_o),
    .int_pin_o(int_pin_o));
`default_nettype wire

// >>> bench/icd_host_model.sv
// Purpose: Host bridge issuing configuration and IO cycles
// Assumes: Requests driven just after a rising edge
// Notes:   Released lines are inverted so stale values never look valid
`timescale 1ns/100ps
`default_nettype none
module icd_host_model
    import icd_pkg::*;
(
    input  wire logic        clk_i,
    output var icd_cfg_req_s cfg_o,
    output var icd_io_req_s  io_o,
    input  wire logic [31:0] rdata_i,
    input  wire logic        rvalid_i,
    input  wire icd_hit_s    hit_i
);
    // Idle bus at time zero
    initial
    begin
        cfg_o = '0;
        io_o = '0;
    end
    // Config write, taken at the edge after it is driven
    task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge clk_i);
        cfg_o <= '{rd: 1'b0, wr: 1'b1, addr: a, be: b, wdata: d};
        @(posedge clk_i);
        cfg_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, be: ~b, wdata: ~d};
        @(negedge clk_i);
    endtask
    // Config read; a missing valid returns a poison word
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        cfg_o <= '{rd: 1'b1, wr: 1'b0, addr: a, be: 4'hF, wdata: 32'h0};
        @(posedge clk_i);
        cfg_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, be: 4'h0, wdata: 32'hFFFF_FFFF};
        @(negedge clk_i);
        d = (rvalid_i === 1'b1) ? rdata_i : 32'hDEAD_BEEF;
    endtask
    // IO cycle; decode is sampled while the address stands
    task automatic probe(input logic [31:0] a, output icd_hit_s h);
        @(posedge clk_i);
        io_o <= '{valid: 1'b1, addr: a};
        @(negedge clk_i);
        h = hit_i;
        @(posedge clk_i);
        io_o <= '{valid: 1'b0, addr: ~a};
    endtask
endmodule // icd_host_model
`default_nettype wire

// >>> bench/ide_config_header_decode_bench.sv
// Purpose: Self-checking bench for the IDE header decode
// Assumes: Host model issues all requests
// Notes:   Table rows first, then hand-written cases
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
    $display("Error %0t: got %h expected %h", $time, (a), (e)); end end
module ide_config_header_decode_bench
    import icd_pkg::*;
;
    typedef struct packed {logic [7:0] pi; logic [7:0] off; logic [31:0] exp;} icd_row_s;
    typedef struct packed {logic [7:0] pi; logic [31:0] a; logic [3:0] h;} icd_io_row_s;
    logic         clk_i;
    logic         srst_i;
    icd_cfg_req_s cfg;
    icd_io_req_s  io;
    logic [31:0]  rdata, rd_d;
    logic         rvalid, pn, sn, pirq, sirq;
    icd_hit_s     hit, h;
    logic [7:0]   line, pin;
    int           miscompares = 0, cmp_count = 0, cycles = 0;
    icd_row_s rows [16] = '{
        '{8'h00, 8'h08, 32'h0101_8A00}, '{8'h00, 8'h10, 0}, '{8'h00, 8'h14, 0},
        '{8'h00, 8'h18, 0}, '{8'h00, 8'h1C, 0}, '{8'h00, 8'h3C, 0},
        '{8'h01, 8'h08, 32'h0101_8B00}, '{8'h01, 8'h10, 32'h1F1}, '{8'h01, 8'h14, 32'h3F5},
        '{8'h01, 8'h3C, 32'h100}, '{8'h04, 8'h1C, 32'h375}, '{8'h04, 8'h18, 32'h171},
        '{8'h04, 8'h14, 0}, '{8'hFF, 8'h08, 32'h0101_8F00}, '{8'h05, 8'h0C, 0},
        '{8'h05, 8'h20, 0}};
    icd_io_row_s io_rows [13] = '{
        '{8'h01, 32'h1234, 4'h8}, '{8'h01, 32'h2002, 4'h4}, '{8'h01, 32'h2000, 4'h0},
        '{8'h01, 32'h1F3, 4'h0}, '{8'h00, 32'h1F7, 4'h8}, '{8'h00, 32'h3F6, 4'h4},
        '{8'h00, 32'h3F7, 4'h0}, '{8'h00, 32'h170, 4'h2}, '{8'h00, 32'h376, 4'h1},
        '{8'h00, 32'h1234, 4'h0}, '{8'h04, 32'h3005, 4'h2}, '{8'h04, 32'h4002, 4'h1},
        '{8'h04, 32'h175, 4'h0}};
    icd_header u_dut (.clk_i(clk_i), .cfg_i(cfg), .io_i(io), .cfg_rdata_o(rdata),
        .cfg_rvalid_o(rvalid), .hit_o(hit), .pri_native_o(pn), .sec_native_o(sn),
        .primary_native_irq_o(pirq), .secondary_native_irq_o(sirq), .int_line_o(line),
        .int_pin_o(pin), .srst_i(srst_i));
    icd_host_model u_host (.clk_i(clk_i), .cfg_o(cfg), .io_o(io), .rdata_i(rdata),
        .rvalid_i(rvalid), .hit_i(hit));
    // Print counts and verdict, then stop
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // 50 ns clock
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // Hang guard
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            miscompares++;
            complete_run();
        end
    end
    // Main sequence
    initial
    begin
        srst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        foreach (rows[i])
        begin
            u_host.wr(8'h08, 4'h2, {16'h0, rows[i].pi, 8'h00});
            u_host.rd(rows[i].off, rd_d);
            `CHK(rd_d, rows[i].exp)
        end
        // Move all bases away from the legacy ports
        u_host.wr(8'h10, 4'hF, 32'h1237);
        u_host.wr(8'h14, 4'hF, 32'h2000);
        u_host.wr(8'h18, 4'hF, 32'h3000);
        u_host.wr(8'h1C, 4'hF, 32'h4000);
        foreach (io_rows[i])
        begin
            u_host.wr(8'h08, 4'h2, {16'h0, io_rows[i].pi, 8'h00});
            u_host.probe(io_rows[i].a, h);
            `CHK(h, io_rows[i].h)
        end
        // Legacy write dropped, native base keeps its low bits fixed
        u_host.wr(8'h10, 4'hF, 32'h5550);
        u_host.wr(8'h08, 4'h2, 32'h0100);
        u_host.rd(8'h10, rd_d);
        `CHK(rd_d, 32'h1231)
        // Line byte writable only in native mode
        u_host.wr(8'h08, 4'h2, 32'h0400);
        u_host.wr(8'h3C, 4'h1, 32'h0E);
        `CHK({pin, line, pirq, sirq}, 18'h00439)
        u_host.wr(8'h08, 4'h2, 32'h0);
        `CHK({pin, line, pirq, sirq}, 18'h0)
        // Only the latency byte stores
        u_host.wr(8'h0C, 4'hF, 32'hFFFF_FFFF);
        u_host.rd(8'h0C, rd_d);
        `CHK(rd_d, 32'h0000_FF00)
        // Reset in mid-run restores modes and bases
        u_host.wr(8'h08, 4'h2, 32'h0500);
        @(posedge clk_i);
        srst_i <= 1'b1;
        @(posedge clk_i);
        srst_i <= 1'b0;
        @(negedge clk_i);
        `CHK({pn, sn}, 2'b00)
        u_host.wr(8'h08, 4'h2, 32'h0100);
        u_host.rd(8'h10, rd_d);
        `CHK(rd_d, 32'h1F1)
        complete_run();
    end
endmodule // ide_config_header_decode_bench
`default_nettype wire

// >>> hdl/icd_defines.svh
// Purpose: Offsets, field positions, reset values and constants of the IDE header decode
// Assumes: Included by the package and the design module
// Notes:   Definitions only
`ifndef ICD_DEFINES_SVH
`define ICD_DEFINES_SVH

// Configuration dword offsets (byte addresses)
`define ICD_OFF_CLASS      8'h08
`define ICD_OFF_BHL        8'h0C
`define ICD_OFF_PCMD       8'h10
`define ICD_OFF_PCTL       8'h14
`define ICD_OFF_SCMD       8'h18
`define ICD_OFF_SCTL       8'h1C
`define ICD_OFF_INTR       8'h3C

// Reset values of the base registers
`define ICD_RST_PCMD       32'h0000_01F1
`define ICD_RST_PCTL       32'h0000_03F5
`define ICD_RST_SCMD       32'h0000_0171
`define ICD_RST_SCTL       32'h0000_0375

// Base field masks: command window 8 bytes, control window 4 bytes
`define ICD_CMD_MASK       32'hFFFF_FFF8
`define ICD_CTL_MASK       32'hFFFF_FFFC
`define ICD_CMD_LOW        32'h0000_0001
`define ICD_CTL_LOW        32'h0000_0001

// Programming-interface fixed bits and field positions
`define ICD_PI_PRI_NATIVE  0
`define ICD_PI_SEC_NATIVE  2
`define ICD_PI_FIXED       8'h8A
`define ICD_PI_RW_MASK     8'h05

// Byte lanes of the writable fields
`define ICD_BYTE_W         8
`define ICD_BYTES          4
`define ICD_LANE_PI        1
`define ICD_LANE_LAT       1
`define ICD_LANE_LINE      0

// Class codes
`define ICD_SUB_CLASS      8'h01
`define ICD_BASE_CLASS     8'h01

// Interrupt pin values and zero byte
`define ICD_INT_PIN_NATIVE 8'h01
`define ICD_ZERO_BYTE      8'h00
`define ICD_ZERO_WORD      32'h0000_0000

// Legacy IO windows
`define ICD_LEG_PCMD       32'h0000_01F0
`define ICD_LEG_PCTL       32'h0000_03F6
`define ICD_LEG_SCMD       32'h0000_0170
`define ICD_LEG_SCTL       32'h0000_0376
`define ICD_CTL_BYTE       32'h0000_0002

`endif

// >>> hdl/icd_header.sv
// Purpose: Configuration header bytes 08h-1Fh and 3Ch of an IDE function with channel decode
// Assumes: Config and IO requests are single-cycle strobes synchronous to clk_i
//          IO addresses are full 32-bit byte addresses
// Notes:   Read data is registered, valid one cycle after the read strobe
//          Base writes to a legacy channel are dropped, not held for later
//          Base bit 0 reads one as at reset while its channel is native; REVISION_ID is arbitrary
//          Offset 3Ch carries only the interrupt line and pin bytes
//          A read and a write in one cycle return the old value
`timescale 1ns/100ps
`default_nettype none
`include "icd_defines.svh"

module icd_header
    import icd_pkg::*;
#(
    parameter logic [7:0] REVISION_ID = 8'h00  // Arbitrary value
)
(
    // Clock
    input  wire logic         clk_i,
    // Configuration and IO cycles from the host
    input  wire icd_cfg_req_s cfg_i,
    input  wire icd_io_req_s  io_i,
    // Configuration read answer
    output logic [31:0]       cfg_rdata_o,
    output logic              cfg_rvalid_o,
    // Channel decode and mode selects
    output icd_hit_s          hit_o,
    output logic              pri_native_o,
    output logic              sec_native_o,
    // Interrupt routing and interrupt fields
    output logic              primary_native_irq_o,
    output logic              secondary_native_irq_o,
    output logic [7:0]        int_line_o,
    output logic [7:0]        int_pin_o,
    // Synchronous reset
    input  wire logic         srst_i
);

    // Stored header fields
    logic [7:0]  progif_q;
    logic [7:0]  latency_q;
    logic [7:0]  int_line_q;
    // Base registers
    logic [31:0] pcmd_q;
    logic [31:0] pctl_q;
    logic [31:0] scmd_q;
    logic [31:0] sctl_q;
    // Read path and mode summary
    logic [31:0] rdata_d;
    logic        any_native;

    // Byte-enable merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < `ICD_BYTES; i++)
        begin
            if (be[i])
            begin
                res[i*`ICD_BYTE_W +: `ICD_BYTE_W] = wd[i*`ICD_BYTE_W +: `ICD_BYTE_W];
            end
        end
        return res;
    endfunction

    // Window hit: address matches base with the given mask
    function automatic logic win_hit(input logic [31:0] a, input logic [31:0] base,
                                     input logic [31:0] mask);
        return (a & mask) == (base & mask);
    endfunction

    // Control window hit: only byte 2 of the 4-byte window answers
    function automatic logic ctl_hit(input logic [31:0] a, input logic [31:0] base);
        return a == ((base & `ICD_CTL_MASK) | `ICD_CTL_BYTE);
    endfunction

    // Mode bit that owns a base offset; offsets without an owner give zero
    function automatic logic base_owner(input logic [7:0] a, input logic pn, input logic sn);
        logic own;
        own = 1'b0;
        if (a == `ICD_OFF_PCMD || a == `ICD_OFF_PCTL)
        begin
            own = pn;
        end
        else if (a == `ICD_OFF_SCMD || a == `ICD_OFF_SCTL)
        begin
            own = sn;
        end
        return own;
    endfunction

    assign pri_native_o = progif_q[`ICD_PI_PRI_NATIVE];
    assign sec_native_o = progif_q[`ICD_PI_SEC_NATIVE];
    assign any_native   = pri_native_o | sec_native_o;

    // Base offsets are visible only while their channel is native
    logic base_vis;
    assign base_vis = base_owner(cfg_i.addr, pri_native_o, sec_native_o);

    // Write strobes per register
    // A legacy channel drops base writes, so no stale base appears later
    logic wr_class;
    logic wr_bhl;
    logic wr_intr;
    logic wr_pcmd;
    logic wr_pctl;
    logic wr_scmd;
    logic wr_sctl;
    always_comb
    begin
        // Every strobe idles low
        wr_class = 1'b0;
        wr_bhl   = 1'b0;
        wr_intr  = 1'b0;
        wr_pcmd  = 1'b0;
        wr_pctl  = 1'b0;
        wr_scmd  = 1'b0;
        wr_sctl  = 1'b0;
        if (!cfg_i.wr)
        begin
            wr_class = 1'b0;
        end
        else if (cfg_i.addr == `ICD_OFF_CLASS)
        begin
            wr_class = 1'b1;
        end
        else if (cfg_i.addr == `ICD_OFF_BHL)
        begin
            wr_bhl = 1'b1;
        end
        else if (cfg_i.addr == `ICD_OFF_PCMD)
        begin
            wr_pcmd = base_vis;
        end
        else if (cfg_i.addr == `ICD_OFF_PCTL)
        begin
            wr_pctl = base_vis;
        end
        else if (cfg_i.addr == `ICD_OFF_SCMD)
        begin
            wr_scmd = base_vis;
        end
        else if (cfg_i.addr == `ICD_OFF_SCTL)
        begin
            wr_sctl = base_vis;
        end
        else if (cfg_i.addr == `ICD_OFF_INTR)
        begin
            wr_intr = any_native;
        end
    end

    // Programming interface: only the two native selects are stored
    // Fixed bits are ORed in on read, so no write can clear them
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            progif_q <= `ICD_ZERO_BYTE;
        end
        else if (wr_class && cfg_i.be[`ICD_LANE_PI])
        begin
            progif_q <= cfg_i.wdata[`ICD_LANE_PI*`ICD_BYTE_W +: `ICD_BYTE_W]
                        & `ICD_PI_RW_MASK;
        end
    end

    // Latency byte: storage only
    // Nothing in the block reads it; software gets back what it wrote
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            latency_q <= `ICD_ZERO_BYTE;
        end
        else if (wr_bhl && cfg_i.be[`ICD_LANE_LAT])
        begin
            latency_q <= cfg_i.wdata[`ICD_LANE_LAT*`ICD_BYTE_W +: `ICD_BYTE_W];
        end
    end

    // Interrupt line byte, writable only in native mode
    // The stored byte survives a switch to legacy, where it reads as zero
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            int_line_q <= `ICD_ZERO_BYTE;
        end
        else if (wr_intr && cfg_i.be[`ICD_LANE_LINE])
        begin
            int_line_q <= cfg_i.wdata[`ICD_LANE_LINE*`ICD_BYTE_W +: `ICD_BYTE_W];
        end
    end

    // Base registers with fixed low bits
    // Low bits are forced on every write so they always stay as at reset
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            pcmd_q <= `ICD_RST_PCMD;
            pctl_q <= `ICD_RST_PCTL;
            scmd_q <= `ICD_RST_SCMD;
            sctl_q <= `ICD_RST_SCTL;
        end
        else
        begin
            // Each base moves only on its own strobe
            if (wr_pcmd)
            begin
                pcmd_q <= (merge(pcmd_q, cfg_i.wdata, cfg_i.be) & `ICD_CMD_MASK)
                          | `ICD_CMD_LOW;
            end
            if (wr_pctl)
            begin
                pctl_q <= (merge(pctl_q, cfg_i.wdata, cfg_i.be) & `ICD_CTL_MASK)
                          | `ICD_CTL_LOW;
            end
            if (wr_scmd)
            begin
                scmd_q <= (merge(scmd_q, cfg_i.wdata, cfg_i.be) & `ICD_CMD_MASK)
                          | `ICD_CMD_LOW;
            end
            if (wr_sctl)
            begin
                sctl_q <= (merge(sctl_q, cfg_i.wdata, cfg_i.be) & `ICD_CTL_MASK)
                          | `ICD_CTL_LOW;
            end
        end
    end

    // Read mux; unmapped offsets read zero
    // A legacy channel's bases read zero, so no window looks programmable
    always_comb
    begin
        rdata_d = `ICD_ZERO_WORD;
        if (cfg_i.addr == `ICD_OFF_CLASS)
        begin
            rdata_d = {`ICD_BASE_CLASS, `ICD_SUB_CLASS,
                       progif_q | `ICD_PI_FIXED, REVISION_ID};
        end
        else if (cfg_i.addr == `ICD_OFF_BHL)
        begin
            rdata_d = {`ICD_ZERO_BYTE, `ICD_ZERO_BYTE, latency_q, `ICD_ZERO_BYTE};
        end
        else if (cfg_i.addr == `ICD_OFF_PCMD)
        begin
            rdata_d = base_vis ? pcmd_q : `ICD_ZERO_WORD;
        end
        else if (cfg_i.addr == `ICD_OFF_PCTL)
        begin
            rdata_d = base_vis ? pctl_q : `ICD_ZERO_WORD;
        end
        else if (cfg_i.addr == `ICD_OFF_SCMD)
        begin
            rdata_d = base_vis ? scmd_q : `ICD_ZERO_WORD;
        end
        else if (cfg_i.addr == `ICD_OFF_SCTL)
        begin
            rdata_d = base_vis ? sctl_q : `ICD_ZERO_WORD;
        end
        else if (cfg_i.addr == `ICD_OFF_INTR)
        begin
            rdata_d = {`ICD_ZERO_BYTE, `ICD_ZERO_BYTE, int_pin_o, int_line_o};
        end
    end

    // Registered read answer
    // Data stays zero outside a read so an idle bus shows nothing stale
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            cfg_rdata_o  <= `ICD_ZERO_WORD;
            cfg_rvalid_o <= 1'b0;
        end
        else
        begin
            cfg_rdata_o  <= cfg_i.rd ? rdata_d : `ICD_ZERO_WORD;
            cfg_rvalid_o <= cfg_i.rd;
        end
    end

    // Interrupt line and pin fields, zero when both channels are legacy
    // Both bytes are shared by the two channels, so either native bit opens them
    assign int_line_o = any_native ? int_line_q : `ICD_ZERO_BYTE;
    assign int_pin_o  = any_native ? `ICD_INT_PIN_NATIVE : `ICD_ZERO_BYTE;

    // IRQ pins dedicated to their channel in native mode
    // In legacy mode the pin stays an ordinary ISA interrupt outside this block
    assign primary_native_irq_o   = pri_native_o;
    assign secondary_native_irq_o = sec_native_o;

    // Channel decode: legacy fixed ports or programmed bases
    // Purely combinational, so a hit stands exactly as long as the IO cycle
    always_comb
    begin
        // Nothing hits without a valid IO cycle
        hit_o = '0;
        if (io_i.valid)
        begin
            // Primary channel
            if (pri_native_o)
            begin
                hit_o.pri_cmd = win_hit(io_i.addr, pcmd_q, `ICD_CMD_MASK);
                hit_o.pri_ctl = ctl_hit(io_i.addr, pctl_q);
            end
            else
            begin
                hit_o.pri_cmd = win_hit(io_i.addr, `ICD_LEG_PCMD, `ICD_CMD_MASK);
                hit_o.pri_ctl = io_i.addr == `ICD_LEG_PCTL;
            end
            // Secondary channel
            if (sec_native_o)
            begin
                hit_o.sec_cmd = win_hit(io_i.addr, scmd_q, `ICD_CMD_MASK);
                hit_o.sec_ctl = ctl_hit(io_i.addr, sctl_q);
            end
            else
            begin
                hit_o.sec_cmd = win_hit(io_i.addr, `ICD_LEG_SCMD, `ICD_CMD_MASK);
                hit_o.sec_ctl = io_i.addr == `ICD_LEG_SCTL;
            end
        end
    end

endmodule // icd_header
`default_nettype wire

// >>> hdl/icd_pkg.sv
// Purpose: Types of the IDE header decode
// Assumes: icd_defines.svh holds the numbers
// Notes:   Types only
`include "icd_defines.svh"
package icd_pkg;
    // Configuration access from the host side
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } icd_cfg_req_s;

    // IO cycle address presented to the channel decoders
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } icd_io_req_s;

    // Channel decode hits
    typedef struct packed {
        logic pri_cmd;
        logic pri_ctl;
        logic sec_cmd;
        logic sec_ctl;
    } icd_hit_s;
endpackage
